// file: dac_ctrl_pkg.sv
// Constants shared by the DAC control block: command codes, frame layout,
// field positions and reset values.
// Assumes a 32-bit (or 24-bit) serial frame, MSB first, command byte first.
package dac_ctrl_pkg;

  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned SHORT_FRAME_BITS = 24;
  localparam int unsigned CRC_BITS = 6;
  localparam int unsigned BIT_COUNT_WIDTH = 16;

  localparam logic [7:0] CMD_WRITE_CONFIG = 8'h70;
  localparam logic [7:0] CMD_WRITE_POWER_DOWN = 8'h71;
  localparam logic [7:0] CMD_WRITE_FAULT = 8'h76;
  localparam logic [7:0] CMD_READ_CONFIG = 8'hF0;
  localparam logic [7:0] CMD_READ_POWER_DOWN = 8'hF1;
  localparam logic [7:0] CMD_READ_FAULT = 8'hF6;
  // Update-class command nibble; low nibble addresses the channel
  localparam logic [3:0] CMD_UPDATE_HI = 4'h6;
  localparam logic [3:0] CMD_TOGGLE_HI = 4'h8;

  // Positions inside the 24-bit data word (bytes 1..3)
  localparam int unsigned CFG_RESET_BIT = 23;
  localparam int unsigned CFG_THERMAL_OFF_BIT = 10;
  localparam int unsigned CFG_OUTSIDE_REFERENCE_SELECT_BIT = 9;
  localparam int unsigned CFG_CRC_EN_BIT = 8;
  localparam int unsigned FAULT_THERMAL_BIT = 10;
  localparam int unsigned FAULT_CLOCK_BIT = 9;
  localparam int unsigned FAULT_CRC_BIT = 8;
  // Channel n sits at data bit 2*n + PD_FIELD_BASE
  localparam int unsigned PD_FIELD_BASE = 8;

  localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
  localparam logic [2:0] FAULT_RESET = 3'h0;
  localparam logic [2:0] CONFIG_RESET = 3'h0;
  localparam logic [6:0] CRC_POLY = 7'h43;

endpackage

// file: dac_sync_bit.sv
// Two-flop level synchroniser into the system clock domain.
// Assumes the input is a level from another domain or a pin.
`timescale 1ns/1ps
`default_nettype none
module dac_sync_bit #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage_one;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage_one <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// file: dac_frame_rx.sv
// Serial link side: shifts frames in on the serial clock and out on its
// falling edge. Assumes the serial clock stands still while select is high.
`timescale 1ns/1ps
`default_nettype none
module dac_frame_rx (
  input wire logic link_sck,
  input wire logic frame_select_load,
  input wire logic serial_in,
  input wire logic [31:0] read_word,
  output logic [31:0] shift_word,
  output logic [15:0] bit_count,
  output logic [5:0] crc_state,
  output logic serial_out
);
  logic [31:0] out_word;
  logic rx_fresh;
  logic tx_started;

  // ----------------------------------------------------------------
  // Receive shift, count and running CRC over all bits
  // ----------------------------------------------------------------
  // Frame start marker: armed while select is high, cleared by first edge
  always_ff @(posedge link_sck or posedge frame_select_load) begin
    if (frame_select_load) begin
      rx_fresh <= 1'b1;
    end else begin
      rx_fresh <= 1'b0;
    end
  end

  // Words hold after select rises, until the next frame's first edge
  always_ff @(posedge link_sck) begin
    if (rx_fresh) begin
      bit_count <= 16'h0001;
      shift_word <= {31'h0000_0000, serial_in};
      crc_state <= serial_in ? dac_ctrl_pkg::CRC_POLY[5:0] : 6'h00;
    end else begin
      bit_count <= bit_count + 16'h0001;
      shift_word <= {shift_word[30:0], serial_in};
      crc_state <= {crc_state[4:0], 1'b0} ^
        ((crc_state[5] ^ serial_in) ? dac_ctrl_pkg::CRC_POLY[5:0] : 6'h00);
    end
  end

  // ----------------------------------------------------------------
  // Transmit: read data loaded at frame start, shifted on falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge link_sck or posedge frame_select_load) begin
    if (frame_select_load) begin
      tx_started <= 1'b0;
    end else begin
      tx_started <= 1'b1;
    end
  end

  always_ff @(negedge link_sck) begin
    if (!tx_started) begin
      out_word <= {read_word[30:0], 1'b0};
    end else begin
      out_word <= {out_word[30:0], 1'b0};
    end
  end

  // First bit comes straight from the read word before any falling edge
  assign serial_out = tx_started ? out_word[31] : read_word[31];
endmodule
`default_nettype wire

// file: dac_powerdown_fault_config.sv
// Power-down, asynchronous load, fault flags and configuration of an
// eight-channel serially programmed DAC.
// Assumes a host drives link_sck, serial_in and frame_select_load, and that
// the analog side consumes the channel power and update outputs.
`timescale 1ns/1ps
`default_nettype none
module dac_powerdown_fault_config #(
  parameter int unsigned NUM_CHANNELS = dac_ctrl_pkg::NUM_CHANNELS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic link_sck,
  input wire logic frame_select_load,
  input wire logic serial_in,
  input wire logic async_load_pin_n,
  input wire logic clear_input_pin_n,
  input wire logic over_temperature,
  output logic serial_out,
  output logic serial_out_en,
  output logic fault_out,
  output logic fault_out_en,
  output logic [7:0] channel_power_down,
  output logic [7:0] channel_update,
  output logic sleep_mode,
  output logic thermal_protect,
  output logic outside_reference_select,
  output logic reference_bypass_charge,
  output logic [7:0] frame_command,
  output logic frame_execute
);

  // Elaboration check on the channel count
  if (NUM_CHANNELS != dac_ctrl_pkg::NUM_CHANNELS) begin : g_channel_check
    $error("Only eight channels are supported");
  end

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic [31:0] shift_word;
  logic [15:0] bit_count;
  logic [5:0] crc_state;
  logic link_serial_out;
  logic [31:0] read_word;

  dac_frame_rx u_frame_rx (
    .link_sck(link_sck),
    .frame_select_load(frame_select_load),
    .serial_in(serial_in),
    .read_word(read_word),
    .shift_word(shift_word),
    .bit_count(bit_count),
    .crc_state(crc_state),
    .serial_out(link_serial_out)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic select_sync;
  logic load_n_sync;
  logic clear_n_sync;
  logic hot_sync;
  logic sdo_sync;

  dac_sync_bit #(.RESET_VALUE(1'b1)) u_sync_select (
    .sys_clk(sys_clk), .srst(srst),
    .async_in(frame_select_load), .sync_out(select_sync));
  dac_sync_bit #(.RESET_VALUE(1'b1)) u_sync_load (
    .sys_clk(sys_clk), .srst(srst),
    .async_in(async_load_pin_n), .sync_out(load_n_sync));
  dac_sync_bit #(.RESET_VALUE(1'b1)) u_sync_clear (
    .sys_clk(sys_clk), .srst(srst),
    .async_in(clear_input_pin_n), .sync_out(clear_n_sync));
  dac_sync_bit #(.RESET_VALUE(1'b0)) u_sync_hot (
    .sys_clk(sys_clk), .srst(srst),
    .async_in(over_temperature), .sync_out(hot_sync));
  dac_sync_bit #(.RESET_VALUE(1'b0)) u_sync_sdo (
    .sys_clk(sys_clk), .srst(srst),
    .async_in(link_serial_out), .sync_out(sdo_sync));

  // ----------------------------------------------------------------
  // Frame end detection
  // ----------------------------------------------------------------
  logic select_prev;
  logic load_n_prev;
  logic clear_n_prev;
  logic select_rise;
  logic load_fall;
  logic clear_fall;
  logic load_low_in_frame;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      select_prev <= 1'b1;
      load_n_prev <= 1'b1;
      clear_n_prev <= 1'b1;
    end else begin
      select_prev <= select_sync;
      load_n_prev <= load_n_sync;
      clear_n_prev <= clear_n_sync;
    end
  end

  assign select_rise = select_sync && !select_prev;
  assign load_fall = !load_n_sync && load_n_prev;
  assign clear_fall = !clear_n_sync && clear_n_prev;

  // Frame words are stable while select is high and the clock stands still
  logic [31:0] frame_word;
  logic [15:0] frame_bits;
  logic [5:0] frame_crc;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frame_word <= 32'h0000_0000;
      frame_bits <= 16'h0000;
      frame_crc <= 6'h00;
    end else if (select_rise) begin
      frame_word <= shift_word;
      frame_bits <= bit_count;
      frame_crc <= crc_state;
    end
  end

  logic frame_valid;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frame_valid <= 1'b0;
      load_low_in_frame <= 1'b0;
    end else begin
      frame_valid <= select_rise;
      if (select_rise) begin
        load_low_in_frame <= !load_n_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // Channel n sits at bit 2n of the sixteen-bit field
  function automatic logic [7:0] pick_channels(input logic [15:0] word);
    logic [7:0] result;
    result = 8'h00;
    for (int i = 0; i < 8; i++) begin
      result[i] = word[2 * i];
    end
    return result;
  endfunction

  function automatic logic [15:0] spread_channels(input logic [7:0] bits);
    logic [15:0] result;
    result = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      result[2 * i] = bits[i];
    end
    return result;
  endfunction

  logic is_long;
  logic [7:0] cmd;
  logic [23:0] data;
  logic count_ok;
  logic crc_exempt;
  logic crc_enable;
  logic crc_bad;
  logic cmd_ok;

  assign is_long = (frame_bits[4:0] == 5'd0) && (frame_bits != 16'h0000);
  assign count_ok = is_long ||
    (frame_bits == 16'(dac_ctrl_pkg::SHORT_FRAME_BITS));
  assign cmd = is_long ? frame_word[31:24] : frame_word[23:16];
  assign data = is_long ? frame_word[23:0] : {frame_word[15:0], 8'h00};
  assign crc_exempt = (cmd == dac_ctrl_pkg::CMD_WRITE_CONFIG) ||
    (cmd == dac_ctrl_pkg::CMD_READ_CONFIG) ||
    (cmd == dac_ctrl_pkg::CMD_WRITE_FAULT) ||
    (cmd == dac_ctrl_pkg::CMD_READ_FAULT);
  // Remainder over whole frame incl. appended check is zero when good
  assign crc_bad = crc_enable && !crc_exempt &&
    (!is_long || frame_crc != 6'h00);
  assign cmd_ok = frame_valid && count_ok && !crc_bad;

  // ----------------------------------------------------------------
  // Software reset and clear
  // ----------------------------------------------------------------
  logic soft_reset;
  assign soft_reset = cmd_ok && (cmd == dac_ctrl_pkg::CMD_WRITE_CONFIG) &&
    data[dac_ctrl_pkg::CFG_RESET_BIT];
  logic wipe;
  assign wipe = soft_reset || clear_fall;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic thermal_guard_off;
  always_ff @(posedge sys_clk) begin
    if (srst || wipe) begin
      thermal_guard_off <= dac_ctrl_pkg::CONFIG_RESET[2];
      outside_reference_select <= dac_ctrl_pkg::CONFIG_RESET[1];
      crc_enable <= dac_ctrl_pkg::CONFIG_RESET[0];
    end else if (cmd_ok && cmd == dac_ctrl_pkg::CMD_WRITE_CONFIG) begin
      thermal_guard_off <= data[dac_ctrl_pkg::CFG_THERMAL_OFF_BIT];
      outside_reference_select <= data[dac_ctrl_pkg::CFG_OUTSIDE_REFERENCE_SELECT_BIT];
      crc_enable <= data[dac_ctrl_pkg::CFG_CRC_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reference_bypass_charge <= 1'b1;
      thermal_protect <= 1'b0;
    end else begin
      reference_bypass_charge <= !outside_reference_select;
      thermal_protect <= hot_sync && !thermal_guard_off;
    end
  end

  // ----------------------------------------------------------------
  // Power-down register and updates
  // ----------------------------------------------------------------
  logic [7:0] update_hit;
  logic toggle_hit;
  logic [7:0] next_power_down;
  logic [7:0] next_update;

  always_comb begin
    update_hit = 8'h00;
    toggle_hit = 1'b0;
    if (cmd_ok && cmd[7:4] == dac_ctrl_pkg::CMD_UPDATE_HI &&
        cmd[3:0] < 4'd8) begin
      update_hit[cmd[2:0]] = 1'b1;
    end
    if (cmd_ok && cmd[7:4] == dac_ctrl_pkg::CMD_TOGGLE_HI) begin
      toggle_hit = 1'b1;
    end
  end

  always_comb begin
    next_power_down = channel_power_down & ~update_hit;
    if (cmd_ok && cmd == dac_ctrl_pkg::CMD_WRITE_POWER_DOWN &&
        !load_low_in_frame) begin
      next_power_down = pick_channels(data[23:8]);
    end
    if (toggle_hit && &channel_power_down) begin
      next_power_down = 8'h00;
    end
    if (!load_n_sync) begin
      next_power_down = 8'h00;
    end
    if (wipe) begin
      next_power_down = dac_ctrl_pkg::POWER_DOWN_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_power_down <= dac_ctrl_pkg::POWER_DOWN_RESET;
      sleep_mode <= 1'b0;
    end else begin
      channel_power_down <= next_power_down;
      sleep_mode <= &next_power_down;
    end
  end

  always_comb begin
    next_update = update_hit;
    if (load_fall && select_sync) begin
      next_update = 8'hFF;
    end
    if (frame_valid && load_low_in_frame) begin
      next_update = 8'hFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_update <= 8'h00;
      frame_command <= 8'h00;
      frame_execute <= 1'b0;
    end else begin
      channel_update <= next_update;
      frame_command <= cmd;
      frame_execute <= cmd_ok;
    end
  end

  // ----------------------------------------------------------------
  // Fault flags and fault output
  // ----------------------------------------------------------------
  logic [2:0] fault_flags;
  logic [2:0] fault_set;
  logic [2:0] next_fault;

  assign fault_set = {hot_sync && !thermal_guard_off,
    frame_valid && !count_ok,
    frame_valid && count_ok && crc_bad};

  always_comb begin
    next_fault = fault_flags;
    if (wipe) begin
      next_fault = dac_ctrl_pkg::FAULT_RESET;
    end else if (cmd_ok && cmd == dac_ctrl_pkg::CMD_WRITE_FAULT) begin
      next_fault = data[dac_ctrl_pkg::FAULT_THERMAL_BIT:
        dac_ctrl_pkg::FAULT_CRC_BIT];
    end
    next_fault = next_fault | fault_set;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_flags <= dac_ctrl_pkg::FAULT_RESET;
    end else begin
      fault_flags <= next_fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_out_en <= 1'b0;
    end else if (|fault_set) begin
      fault_out_en <= 1'b1;
    end else if (select_rise) begin
      fault_out_en <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_out <= 1'b0;
    end else begin
      fault_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read-back word for next frame
  // ----------------------------------------------------------------
  logic [31:0] next_read;
  always_comb begin
    next_read = 32'h0000_0000;
    if (cmd == dac_ctrl_pkg::CMD_READ_POWER_DOWN) begin
      next_read = {cmd, spread_channels(channel_power_down), 8'h00};
    end else if (cmd == dac_ctrl_pkg::CMD_READ_FAULT) begin
      next_read = {cmd, 13'h0000, fault_flags, 8'h00};
    end else if (cmd == dac_ctrl_pkg::CMD_READ_CONFIG) begin
      next_read = {cmd, 13'h0000, thermal_guard_off,
        outside_reference_select, crc_enable, 8'h00};
    end
  end

  // Held stable while select is low; link side loads it at frame start
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      read_word <= 32'h0000_0000;
    end else if (cmd_ok) begin
      read_word <= next_read;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      serial_out <= sdo_sync;
      serial_out_en <= !select_sync;
    end
  end

endmodule
`default_nettype wire

// file: dac_ctrl_check_asserts.sv
// Concurrent checks on the ports of the DAC control block.
// Assumes binding onto dac_powerdown_fault_config, one sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_check (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic frame_select_load,
  input wire logic async_load_pin_n,
  input wire logic clear_input_pin_n,
  input wire logic over_temperature,
  input wire logic fault_out,
  input wire logic fault_out_en,
  input wire logic serial_out_en,
  input wire logic [7:0] channel_power_down,
  input wire logic [7:0] channel_update,
  input wire logic sleep_mode,
  input wire logic thermal_protect,
  input wire logic outside_reference_select,
  input wire logic reference_bypass_charge,
  input wire logic frame_execute
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_sleep_on;
    (channel_power_down == 8'hFF) [*3] |-> sleep_mode;
  endproperty
  a_sleep_on: assert property (p_sleep_on)
    else $error("sleep missing with all channels down");
  property p_sleep_off;
    (channel_power_down != 8'hFF) [*3] |-> !sleep_mode;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep held with a channel up");
  property p_bypass;
    $stable(outside_reference_select) [*2]
      |-> reference_bypass_charge != outside_reference_select;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass charge not inverse of reference select");
  property p_fault_pin;
    fault_out == 1'b0 && (!$fell(fault_out_en) || frame_select_load);
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin driven high or released inside a frame");
  property p_update_up;
    $rose(channel_update[0]) |-> ##[0:2] !channel_power_down[0];
  endproperty
  a_update_up: assert property (p_update_up)
    else $error("updated channel stays down");
  property p_load_up;
    $fell(async_load_pin_n) |-> ##[2:6] (channel_power_down == 8'h00);
  endproperty
  a_load_up: assert property (p_load_up)
    else $error("load pin did not power up");
  property p_clear;
    $fell(clear_input_pin_n) |-> ##[2:6]
      (channel_power_down == 8'h00 && !outside_reference_select);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not restore defaults");
  property p_thermal_off;
    !over_temperature [*5] |-> !thermal_protect;
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("thermal protect without over temperature");
  property p_serial_en;
    frame_select_load [*4] |-> !serial_out_en;
  endproperty
  a_serial_en: assert property (p_serial_en)
    else $error("serial output driven outside frame");
  property p_exec;
    frame_execute |-> frame_select_load;
  endproperty
  a_exec: assert property (p_exec)
    else $error("frame executed while select low");
endmodule
`default_nettype wire

// file: dac_host_model.sv
// Host serial controller model: frames, CRC append, read capture.
// Assumes the link clock stands low outside frames.
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
  output logic link_sck,
  output logic frame_select_load,
  output logic serial_in,
  input wire logic serial_out
);
  // ------------------------------------------------------------
  // Frame driver
  // ------------------------------------------------------------
  // Rising select at start arms the link-side frame markers
  initial begin
    link_sck = 1'b0;
    frame_select_load = 1'b0;
    serial_in = 1'b0;
    #1 frame_select_load = 1'b1;
  end
  function automatic logic [5:0] crc6(input logic [25:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h00;
    for (int i = 25; i >= 0; i--) begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return c;
  endfunction
  // Sends the low n bits of w MSB first; good=0 corrupts the CRC
  task automatic frame(input logic [31:0] w, input int n, input bit good,
                       output logic [31:0] rd);
    logic [31:0] t;
    t = w;
    rd = 32'h0000_0000;
    if (n == 32) begin
      t[5:0] = crc6(w[31:6]) ^ {5'h00, ~good};
    end
    #3 frame_select_load = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = t[i];
      #16 link_sck = 1'b1;
      #16 rd = {rd[30:0], serial_out};
      link_sck = 1'b0;
    end
    #16 frame_select_load = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the DAC power-down, fault and config block.
// Assumes dac_host_model drives the link and the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic async_load_pin_n = 1'b1;
  logic clear_input_pin_n = 1'b1;
  logic over_temperature = 1'b0;
  logic link_sck, frame_select_load, serial_in, serial_out, serial_out_en;
  logic fault_out, fault_out_en, sleep_mode, thermal_protect, frame_execute;
  logic outside_reference_select, reference_bypass_charge, upd_clr = 1'b0;
  logic [7:0] channel_power_down, channel_update, frame_command;
  logic [7:0] seen_upd = 8'h00;
  logic [31:0] rd;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  always #4 sys_clk = ~sys_clk;
  dac_powerdown_fault_config i_dut (.sys_clk, .srst, .link_sck,
    .frame_select_load, .serial_in, .async_load_pin_n, .clear_input_pin_n,
    .over_temperature, .serial_out, .serial_out_en, .fault_out,
    .fault_out_en, .channel_power_down, .channel_update, .sleep_mode,
    .thermal_protect, .outside_reference_select, .reference_bypass_charge,
    .frame_command, .frame_execute);
  dac_host_model i_host (.link_sck, .frame_select_load, .serial_in,
    .serial_out);

  always @(posedge sys_clk) begin
    seen_upd <= upd_clr ? 8'h00 : (seen_upd | channel_update);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report;
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [15:0] spread(input logic [7:0] p);
    logic [15:0] r;
    r = 16'h0000;
    for (int n = 0; n < 8; n++) r[2*n] = p[n];
    return r;
  endfunction
  task automatic wr(input logic [7:0] c, input logic [15:0] f,
                    input bit good = 1'b1);
    i_host.frame({c, f, 8'h00}, 32, good, rd);
    tick(2);
  endtask
  task automatic rdf(input logic [7:0] c, input logic [15:0] m,
                     input logic [15:0] e, input string s);
    wr(c, 16'h0000);
    wr(c, 16'h0000);
    chk(s, e & m, rd[23:8] & m);
  endtask
  task automatic clr_upd;
    upd_clr <= 1'b1;
    tick(1);
    upd_clr <= 1'b0;
  endtask

  initial begin
    tick(4);
    srst <= 1'b0;
    tick(4);
    chk("pd", 8'h00, channel_power_down);
    chk("bypass", 1'b1, reference_bypass_charge);
    i_host.frame({8'h00, dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hA5)},
      24, 1'b1, rd);
    tick(2);
    chk("pd", 8'hA5, channel_power_down);
    rdf(dac_ctrl_pkg::CMD_READ_POWER_DOWN, 16'h5555, spread(8'hA5),
      "pd_read");
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hFF));
    chk("sleep", 1'b1, sleep_mode);
    clr_upd();
    wr({dac_ctrl_pkg::CMD_UPDATE_HI, 4'h3}, 16'h0000);
    chk("upd", 8'h08, seen_upd);
    chk("pd", 8'hF7, channel_power_down);
    chk("cmd", {dac_ctrl_pkg::CMD_UPDATE_HI, 4'h3}, frame_command);
    chk("sleep", 1'b0, sleep_mode);
    async_load_pin_n <= 1'b0;
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hFF));
    chk("pd", 8'h00, channel_power_down);
    async_load_pin_n <= 1'b1;
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hFF));
    clr_upd();
    async_load_pin_n <= 1'b0;
    tick(8);
    chk("pd", 8'h00, channel_power_down);
    chk("upd", 8'hFF, seen_upd);
    async_load_pin_n <= 1'b1;
    i_host.frame(32'h0000_0000, 20, 1'b1, rd);
    tick(2);
    chk("fault_pin", 1'b1, fault_out_en);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0002, "ckf");
    chk("fault_pin", 1'b0, fault_out_en);
    wr(dac_ctrl_pkg::CMD_WRITE_FAULT, 16'h0000);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0000, "flt");
    wr(dac_ctrl_pkg::CMD_WRITE_CONFIG, 16'h0001);
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'h0F), 1'b0);
    chk("pd", 8'h00, channel_power_down);
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'h0F));
    chk("pd", 8'h0F, channel_power_down);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0001, "cf");
    wr(dac_ctrl_pkg::CMD_WRITE_FAULT, 16'h0000, 1'b0);
    wr(dac_ctrl_pkg::CMD_WRITE_CONFIG, 16'h0000, 1'b0);
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'h3C), 1'b0);
    chk("pd", 8'h3C, channel_power_down);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0000, "flt");
    over_temperature <= 1'b1;
    tick(8);
    chk("thermal", 1'b1, thermal_protect);
    chk("fault_pin", 1'b1, fault_out_en);
    wr(dac_ctrl_pkg::CMD_WRITE_CONFIG, 16'h0004);
    tick(4);
    chk("thermal", 1'b0, thermal_protect);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0004, "tsf");
    over_temperature <= 1'b0;
    wr(dac_ctrl_pkg::CMD_WRITE_CONFIG, 16'h0002);
    chk("outside_reference_select", 1'b1, outside_reference_select);
    chk("bypass", 1'b0, reference_bypass_charge);
    wr(dac_ctrl_pkg::CMD_WRITE_CONFIG, 16'h8002);
    chk("pd", 8'h00, channel_power_down);
    chk("outside_reference_select", 1'b0, outside_reference_select);
    rdf(dac_ctrl_pkg::CMD_READ_CONFIG, 16'hFFFF, 16'h0000, "cfg");
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hFF));
    i_host.frame(32'h0000_0000, 20, 1'b1, rd);
    tick(2);
    clear_input_pin_n <= 1'b0;
    tick(2);
    clear_input_pin_n <= 1'b1;
    tick(8);
    chk("pd", 8'h00, channel_power_down);
    chk("sleep", 1'b0, sleep_mode);
    wr(dac_ctrl_pkg::CMD_WRITE_POWER_DOWN, spread(8'hFF));
    wr({dac_ctrl_pkg::CMD_TOGGLE_HI, 4'h0}, 16'h0000);
    chk("pd", 8'h00, channel_power_down);
    rdf(dac_ctrl_pkg::CMD_READ_FAULT, 16'hFFFF, 16'h0000, "flt");
    final_report();
  end
endmodule

bind dac_powerdown_fault_config dac_ctrl_check i_chk (.sys_clk, .srst,
  .frame_select_load, .async_load_pin_n, .clear_input_pin_n,
  .over_temperature, .fault_out, .fault_out_en, .serial_out_en,
  .channel_power_down,
  .channel_update, .sleep_mode, .thermal_protect, .outside_reference_select,
  .reference_bypass_charge, .frame_execute);
`default_nettype wire
